// ===== hdl/interrupt_vector_priority_map.sv
// Notes on behaviour
// RULE_01 - Four priority levels for peripheral sources
// RULE_02 - Two-bit priority field per source only
// RULE_03 - NMI pin drives non-maskable request
// RULE_04 - NMI only while pin function selected
// RULE_05 - IRQ number equals vector minus sixteen
// RULE_06 - Taken vector number is the stacked value
// RULE_07 - Table entry address is four times vector
// RULE_08 - Vectors 0-3: SP, PC, NMI, fault
// RULE_09 - 11 svc, 14 pendsv, 15 tick; others unused
// RULE_10 - IRQ 0-3 carry DMA channels
// RULE_11 - IRQ 4 spare, 5 flash, 6 power
// RULE_12 - IRQ 7 wakeup, 8-9 I2C, 10-11 SPI
// RULE_13 - IRQ 12-19 serial, ADC, comparator, timers
// RULE_14 - IRQ 20-22 RTC and PERIODIC_INTERRUPT_TIMER; 23 spare
// RULE_15 - IRQ 24-31 USB..ports, 29 spare
// RULE_16 - Priority register index is IRQ div 4
// RULE_17 - Field starts at 8*(IRQ mod 4)+6
// RULE_18 - Full 32-line request vector
// RULE_19 - Unassigned IRQ lines tied inactive
// RULE_20 - Priorities reset to zero
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_priority_map #(
    parameter int NUM_IRQ = 32
) (
    input  wire logic        clk,             // Core clock
    input  wire logic        rst_n,           // Sync reset, active low
    input  wire logic [3:0]  dma_req,         // DMA channel requests
    input  wire logic        flash_req,       // Flash controller request
    input  wire logic        power_req,       // Low-voltage request
    input  wire logic        wakeup_req,      // Wakeup unit request
    input  wire logic [1:0]  i2c_req,         // Two-wire serial requests
    input  wire logic [1:0]  spi_req,         // Serial peripheral requests
    input  wire logic [2:0]  uart_req,        // Async serial requests
    input  wire logic        adc_req,         // Converter request
    input  wire logic        cmp_req,         // Comparator request
    input  wire logic [2:0]  tpm_req,         // Timer-PWM requests
    input  wire logic        rtc_alarm_req,   // RTC alarm
    input  wire logic        rtc_sec_req,     // RTC seconds
    input  wire logic        pit_req,         // Periodic timer
    input  wire logic        usb_req,         // USB controller
    input  wire logic        dac_req,         // DAC
    input  wire logic        tsi_req,         // Touch sensing
    input  wire logic        clkgen_req,      // Clock generator
    input  wire logic        lptmr_req,       // Low-power timer
    input  wire logic        porta_req,       // Port A pin detect
    input  wire logic        portd_req,       // Port D pin detect
    input  wire logic        nmi_pin_n,       // NMI pin, async, active low
    input  wire logic        nmi_pin_select,  // Pin mux has NMI function
    input  wire logic        prio_wr,         // Priority register write
    input  wire logic [2:0]  prio_wr_index,   // Register written
    input  wire logic [31:0] prio_wr_data,    // Write data
    input  wire logic [2:0]  prio_rd_index,   // Register read
    output logic [31:0]      prio_rd_data,    // Read data, one cycle later
    input  wire logic        core_ack,        // Core takes an exception
    output logic             irq_pending,     // Peripheral request pending
    output logic [4:0]       irq_number,      // Winning IRQ
    output logic [1:0]       irq_priority,    // Its level
    output logic             nmi_request,     // Non-maskable request
    output logic             exc_taken,       // Pulse: exception taken
    output logic [5:0]       exc_vector,      // Vector number to stack
    output logic [31:0]      exc_vector_addr, // Table entry address
    input  wire logic        fetch_req,       // Core fetches a vector
    input  wire logic [5:0]  fetch_vector,    // Vector fetched
    output logic [31:0]      fetch_addr,      // Entry address
    output irq_map_pkg::vec_kind_t fetch_kind // Entry class
);
    logic [NUM_IRQ-1:0]   irq_lines;
    logic [2*NUM_IRQ-1:0] prio_flat;
    logic                 sel_any;
    logic [4:0]           sel_irq;
    logic [1:0]           sel_level;
    logic                 nmi_sync1;
    logic                 nmi_sync2;
    logic [31:0]          next_rd_data;
    irq_map_pkg::vec_kind_t next_kind;

    irq_source_map u_map (
        .dma_req       (dma_req),
        .flash_req     (flash_req),
        .power_req     (power_req),
        .wakeup_req    (wakeup_req),
        .i2c_req       (i2c_req),
        .spi_req       (spi_req),
        .uart_req      (uart_req),
        .adc_req       (adc_req),
        .cmp_req       (cmp_req),
        .tpm_req       (tpm_req),
        .rtc_alarm_req (rtc_alarm_req),
        .rtc_sec_req   (rtc_sec_req),
        .pit_req       (pit_req),
        .usb_req       (usb_req),
        .dac_req       (dac_req),
        .tsi_req       (tsi_req),
        .clkgen_req    (clkgen_req),
        .lptmr_req     (lptmr_req),
        .porta_req     (porta_req),
        .portd_req     (portd_req),
        .irq_lines     (irq_lines)                              // RULE_18
    );

    priority_select #(.N(NUM_IRQ)) u_sel (
        .pend      (irq_lines),
        .prio_flat (prio_flat),
        .any       (sel_any),
        .winner    (sel_irq),
        .level     (sel_level)
    );

    // Priority storage: only two bits per source exist, four levels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prio_flat <= '0;                                     // RULE_20
        end else if (prio_wr) begin
            for (int k = 0; k < irq_map_pkg::IRQS_PER_REG; k++) begin
                prio_flat[2*(4*int'(prio_wr_index)+k) +: 2] <=
                    prio_wr_data[irq_map_pkg::field_lsb(5'(k)) +: 2]; // RULE_02 RULE_16 RULE_17
            end
        end
    end

    // Unimplemented bits read as zero
    always_comb begin
        next_rd_data = irq_map_pkg::PRIO_REG_RESET;
        for (int k = 0; k < irq_map_pkg::IRQS_PER_REG; k++) begin
            next_rd_data[irq_map_pkg::field_lsb(5'(k)) +: 2] =
                prio_flat[2*(4*int'(prio_rd_index)+k) +: 2];    // RULE_16 RULE_17
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prio_rd_data <= irq_map_pkg::PRIO_REG_RESET;
        end else begin
            prio_rd_data <= next_rd_data;
        end
    end

    // Pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmi_sync1   <= 1'b1;
            nmi_sync2   <= 1'b1;
            nmi_request <= 1'b0;
        end else begin
            nmi_sync1   <= nmi_pin_n;
            nmi_sync2   <= nmi_sync1;
            nmi_request <= !nmi_sync2 && nmi_pin_select;         // RULE_03 RULE_04
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_pending  <= 1'b0;
            irq_number   <= 5'h00;
            irq_priority <= irq_map_pkg::PRIO_RESET;
        end else begin
            irq_pending  <= sel_any;
            irq_number   <= sel_irq;
            irq_priority <= sel_level;                           // RULE_01
        end
    end

    // NMI outranks every peripheral level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exc_taken       <= 1'b0;
            exc_vector      <= irq_map_pkg::VEC_INIT_SP;
            exc_vector_addr <= irq_map_pkg::TABLE_BASE;
        end else begin
            exc_taken <= core_ack && (nmi_request || irq_pending);
            if (core_ack && nmi_request) begin
                exc_vector      <= irq_map_pkg::VEC_NMI;         // RULE_08
                exc_vector_addr <= irq_map_pkg::vector_addr(irq_map_pkg::VEC_NMI);
            end else if (core_ack && irq_pending) begin
                exc_vector      <= irq_map_pkg::irq_to_vector(irq_number); // RULE_05 RULE_06
                exc_vector_addr <= irq_map_pkg::vector_addr(
                                   irq_map_pkg::irq_to_vector(irq_number)); // RULE_07
            end
        end
    end

    always_comb begin
        case (fetch_vector)
            irq_map_pkg::VEC_INIT_SP,
            irq_map_pkg::VEC_INIT_PC,
            irq_map_pkg::VEC_NMI,
            irq_map_pkg::VEC_HARD_FAULT: next_kind = irq_map_pkg::CORE_USED;   // RULE_08
            irq_map_pkg::VEC_SUPERVISOR,
            irq_map_pkg::VEC_PEND_SVC,
            irq_map_pkg::VEC_SYS_TICK:   next_kind = irq_map_pkg::CORE_USED;   // RULE_09
            default: begin
                if (fetch_vector > irq_map_pkg::LAST_VECTOR) begin
                    next_kind = irq_map_pkg::OUT_OF_TABLE;
                end else if (fetch_vector >= irq_map_pkg::CORE_VECTORS) begin
                    next_kind = irq_map_pkg::PERIPHERAL;
                end else begin
                    next_kind = irq_map_pkg::CORE_UNUSED;        // RULE_09
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fetch_addr <= irq_map_pkg::TABLE_BASE;
            fetch_kind <= irq_map_pkg::CORE_USED;
        end else if (fetch_req) begin
            fetch_addr <= irq_map_pkg::vector_addr(fetch_vector); // RULE_07
            fetch_kind <= next_kind;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_nmi_held;
        (!nmi_pin_n && nmi_pin_select) [*4];
    endsequence

    property p_nmi_path;
        s_nmi_held |-> nmi_request;
    endproperty
    a_nmi_path: assert property (p_nmi_path) else $error("NMI not raised"); // RULE_03

    property p_nmi_select;
        nmi_request |-> $past(nmi_pin_select);
    endproperty
    a_nmi_select: assert property (p_nmi_select) else $error("NMI without pin select"); // RULE_04

    property p_spare_lines;
        (irq_lines & irq_map_pkg::UNASSIGNED_IRQS) == 32'h0000_0000;
    endproperty
    a_spare_lines: assert property (p_spare_lines) else $error("Spare IRQ active"); // RULE_19

    property p_irq_take;
        core_ack && irq_pending && !nmi_request |=>
            exc_taken && exc_vector == $past(irq_number) + 6'h10;
    endproperty
    a_irq_take: assert property (p_irq_take) else $error("Wrong IRQ vector"); // RULE_05

    property p_nmi_take;
        core_ack && nmi_request |=> exc_taken && exc_vector == irq_map_pkg::VEC_NMI;
    endproperty
    a_nmi_take: assert property (p_nmi_take) else $error("NMI vector wrong"); // RULE_08

    property p_addr;
        exc_taken |-> exc_vector_addr == {24'h00_0000, exc_vector, 2'b00};
    endproperty
    a_addr: assert property (p_addr) else $error("Vector address wrong"); // RULE_07

    property p_fetch;
        fetch_req && fetch_vector == 6'h2F |=> fetch_addr == irq_map_pkg::TABLE_LAST
                                          && fetch_kind == irq_map_pkg::PERIPHERAL;
    endproperty
    a_fetch: assert property (p_fetch) else $error("Last entry wrong"); // RULE_07

    property p_unused_kind;
        fetch_req && fetch_vector == 6'h04 |=> fetch_kind == irq_map_pkg::CORE_UNUSED;
    endproperty
    a_unused_kind: assert property (p_unused_kind) else $error("Unused entry class wrong"); // RULE_09

    // A take with nothing pending must leave the stacked vector alone
    property p_refused_take;
        core_ack && !nmi_request && !irq_pending |=> !exc_taken && $stable(exc_vector);
    endproperty
    a_refused_take: assert property (p_refused_take) else $error("Refused take acted"); // RULE_06

    property p_prio_write;
        prio_wr ##1 !prio_wr && prio_rd_index == $past(prio_wr_index) |=>
            prio_rd_data == ($past(prio_wr_data, 2) & 32'hC0C0_C0C0);
    endproperty
    a_prio_write: assert property (p_prio_write) else $error("Priority readback wrong"); // RULE_17

    property p_prio_reset;
        $rose(rst_n) |-> prio_flat == '0;
    endproperty
    a_prio_reset: assert property (@(posedge clk) p_prio_reset) else $error("Priority not reset"); // RULE_20

    property p_pending_src;
        irq_pending |-> $past(irq_lines[sel_irq]) && irq_number == $past(sel_irq)
                        && irq_priority == $past(sel_level);
    endproperty
    a_pending_src: assert property (p_pending_src) else $error("Pending without source"); // RULE_18
endmodule
`default_nettype wire

// ===== hdl/irq_map_pkg.sv
`default_nettype none
package irq_map_pkg;
    localparam int          NUM_IRQ         = 32;
    localparam int          IRQ_W           = 5;
    localparam int          PRIO_W          = 2;
    localparam int          NUM_LEVELS      = 4;
    localparam int          NUM_PRIO_REGS   = 8;
    localparam int          PRIO_REG_W      = 3;
    localparam int          IRQS_PER_REG    = 4;
    localparam int          FIELD_STRIDE    = 8;
    localparam int          FIELD_OFFSET    = 6;
    localparam int          VEC_W           = 6;
    localparam logic [5:0]  CORE_VECTORS    = 6'h10;
    localparam logic [5:0]  LAST_VECTOR     = 6'h2F;
    localparam logic [31:0] TABLE_BASE      = 32'h0000_0000;
    localparam logic [31:0] TABLE_LAST      = 32'h0000_00BC;
    localparam logic [5:0]  VEC_INIT_SP     = 6'h00;
    localparam logic [5:0]  VEC_INIT_PC     = 6'h01;
    localparam logic [5:0]  VEC_NMI         = 6'h02;
    localparam logic [5:0]  VEC_HARD_FAULT  = 6'h03;
    localparam logic [5:0]  VEC_SUPERVISOR  = 6'h0B;
    localparam logic [5:0]  VEC_PEND_SVC    = 6'h0E;
    localparam logic [5:0]  VEC_SYS_TICK    = 6'h0F;
    localparam logic [1:0]  PRIO_RESET      = 2'h0;
    localparam logic [31:0] PRIO_REG_RESET  = 32'h0000_0000;
    localparam logic [31:0] UNASSIGNED_IRQS = 32'h2080_0010;
    localparam int          NMI_SYNC_STAGES = 2;

    typedef enum logic [1:0] {CORE_USED, CORE_UNUSED, PERIPHERAL, OUT_OF_TABLE} vec_kind_t;

    function automatic logic [5:0] irq_to_vector(input logic [4:0] irq);
        return {1'b0, irq} + CORE_VECTORS;
    endfunction

    function automatic logic [31:0] vector_addr(input logic [5:0] vec);
        return TABLE_BASE + {24'h00_0000, vec, 2'b00};
    endfunction

    function automatic logic [2:0] prio_reg_of(input logic [4:0] irq);
        return irq[4:2];
    endfunction

    function automatic int field_lsb(input logic [4:0] irq);
        return FIELD_STRIDE * int'(irq[1:0]) + FIELD_OFFSET;
    endfunction
endpackage
`default_nettype wire

// ===== hdl/irq_source_map.sv
`timescale 1ns/1ns
`default_nettype none
module irq_source_map (
    input  wire logic [3:0]  dma_req,        // DMA channels 0..3
    input  wire logic        flash_req,      // flash_memory_controller
    input  wire logic        power_req,      // power_management_controller
    input  wire logic        wakeup_req,     // low_leakage_wakeup_unit
    input  wire logic [1:0]  i2c_req,        // Two-wire serial 0,1
    input  wire logic [1:0]  spi_req,        // Serial peripheral 0,1
    input  wire logic [2:0]  uart_req,       // Async serial 0..2
    input  wire logic        adc_req,        // Converter
    input  wire logic        cmp_req,        // analog_comparator
    input  wire logic [2:0]  tpm_req,        // timer_pwm_module 0..2
    input  wire logic        rtc_alarm_req,  // RTC alarm
    input  wire logic        rtc_sec_req,    // RTC seconds
    input  wire logic        pit_req,        // periodic_interrupt_timer
    input  wire logic        usb_req,        // USB controller
    input  wire logic        dac_req,        // DAC
    input  wire logic        tsi_req,        // touch_sensing_input
    input  wire logic        clkgen_req,     // multipurpose_clock_generator
    input  wire logic        lptmr_req,      // low_power_timer
    input  wire logic        porta_req,      // Port A pin detect
    input  wire logic        portd_req,      // Port D pin detect
    output logic [31:0]      irq_lines       // Full request vector
);
    logic [31:0] raw;

    always_comb begin
        raw        = 32'h0000_0000;
        raw[3:0]   = dma_req;                                    // RULE_10
        raw[5]     = flash_req;                                  // RULE_11
        raw[6]     = power_req;                                  // RULE_11
        raw[7]     = wakeup_req;                                 // RULE_12
        raw[9:8]   = i2c_req;                                    // RULE_12
        raw[11:10] = spi_req;                                    // RULE_12
        raw[14:12] = uart_req;                                   // RULE_13
        raw[15]    = adc_req;                                    // RULE_13
        raw[16]    = cmp_req;                                    // RULE_13
        raw[19:17] = tpm_req;                                    // RULE_13
        raw[20]    = rtc_alarm_req;                              // RULE_14
        raw[21]    = rtc_sec_req;                                // RULE_14
        raw[22]    = pit_req;                                    // RULE_14
        raw[28:24] = {lptmr_req, clkgen_req, tsi_req, dac_req, usb_req}; // RULE_15
        raw[31:30] = {portd_req, porta_req};                     // RULE_15
    end

    // Belt and braces: spare lines stay low even if a future edit maps them
    assign irq_lines = raw & ~irq_map_pkg::UNASSIGNED_IRQS;      // RULE_19
endmodule
`default_nettype wire

// ===== hdl/priority_select.sv
`timescale 1ns/1ns
`default_nettype none
module priority_select #(
    parameter int N = 32
) (
    input  wire logic [N-1:0]   pend,      // Pending lines
    input  wire logic [2*N-1:0] prio_flat, // 2-bit level per line
    output logic                any,       // Something pending
    output logic [4:0]          winner,    // Chosen line
    output logic [1:0]          level      // Its level
);
    // Lowest level wins; ties go to the lowest line number
    always_comb begin
        any    = 1'b0;
        winner = 5'h00;
        level  = 2'h3;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && (!any || prio_flat[2*i +: 2] <= level)) begin
                any    = 1'b1;
                winner = 5'(i);
                level  = prio_flat[2*i +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input  wire logic        clk,             // Core clock
    input  wire logic        exc_taken,       // Take pulse
    input  wire logic [5:0]  exc_vector,      // Vector to stack
    input  wire logic [31:0] exc_vector_addr, // Entry address of taken vector
    input  wire logic [31:0] fetch_addr,      // Entry address of fetched vector
    input  wire logic [1:0]  fetch_kind,      // Entry class
    output logic             core_ack,        // Take request pulse
    output logic             fetch_req,       // Fetch request
    output logic [5:0]       fetch_vector     // Vector to fetch
);
    initial begin
        core_ack = 1'b0;
        fetch_req = 1'b0;
        fetch_vector = 6'h3F;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Idle cycles first model a core that answers slowly
    task automatic take(input int idle, output logic [1:0] pulse, output logic [5:0] vec,
                        output logic [31:0] addr);
        repeat (idle) tick();
        core_ack = 1'b1;
        tick();
        core_ack = 1'b0;
        pulse[1] = exc_taken;
        vec = exc_vector;
        addr = exc_vector_addr;
        tick();
        pulse[0] = exc_taken;
    endtask

    // Request held across calls for back-to-back fetches
    task automatic fetch(input logic [5:0] v, input bit last, output logic [31:0] addr,
                         output logic [1:0] kind);
        fetch_vector = v;
        fetch_req = 1'b1;
        tick();
        addr = fetch_addr;
        kind = fetch_kind;
        if (last) begin
            fetch_req = 1'b0;
            // Released vector lines must not keep showing the last value
            fetch_vector = ~v;
            tick();
        end
    endtask
endmodule
`default_nettype wire

// ===== dv/interrupt_vector_priority_map_tb.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_priority_map_tb;
    localparam logic [31:0] ASSIGNED = 32'hDF7F_FFEF;
    logic                   clk = 1'b0;
    logic                   rst_n;
    logic [31:0]            src;
    logic                   nmi_pin_n;
    logic                   nmi_pin_select;
    logic                   prio_wr;
    logic [2:0]             prio_wr_index;
    logic [31:0]            prio_wr_data;
    logic [2:0]             prio_rd_index;
    logic [31:0]            prio_rd_data;
    logic                   core_ack;
    logic                   irq_pending;
    logic [4:0]             irq_number;
    logic [1:0]             irq_priority;
    logic                   nmi_request;
    logic                   exc_taken;
    logic [5:0]             exc_vector;
    logic [31:0]            exc_vector_addr;
    logic                   fetch_req;
    logic [5:0]             fetch_vector;
    logic [31:0]            fetch_addr;
    irq_map_pkg::vec_kind_t fetch_kind;
    logic [1:0]             prio [32];
    int                     errors = 0;
    int                     n_compared = 0;
    int                     cycles = 0;

    always #50 clk = ~clk;

    interrupt_vector_priority_map #(.NUM_IRQ(32)) u_interrupt_vector_priority_map (
        .clk(clk), .rst_n(rst_n), .dma_req(src[3:0]), .flash_req(src[5]),
        .power_req(src[6]), .wakeup_req(src[7]), .i2c_req(src[9:8]), .spi_req(src[11:10]),
        .uart_req(src[14:12]), .adc_req(src[15]), .cmp_req(src[16]), .tpm_req(src[19:17]),
        .rtc_alarm_req(src[20]), .rtc_sec_req(src[21]), .pit_req(src[22]),
        .usb_req(src[24]), .dac_req(src[25]), .tsi_req(src[26]), .clkgen_req(src[27]),
        .lptmr_req(src[28]), .porta_req(src[30]), .portd_req(src[31]),
        .nmi_pin_n(nmi_pin_n), .nmi_pin_select(nmi_pin_select), .prio_wr(prio_wr),
        .prio_wr_index(prio_wr_index), .prio_wr_data(prio_wr_data),
        .prio_rd_index(prio_rd_index), .prio_rd_data(prio_rd_data), .core_ack(core_ack),
        .irq_pending(irq_pending), .irq_number(irq_number), .irq_priority(irq_priority),
        .nmi_request(nmi_request), .exc_taken(exc_taken), .exc_vector(exc_vector),
        .exc_vector_addr(exc_vector_addr), .fetch_req(fetch_req),
        .fetch_vector(fetch_vector), .fetch_addr(fetch_addr), .fetch_kind(fetch_kind));

    core_model u_core_model (
        .clk(clk), .exc_taken(exc_taken), .exc_vector(exc_vector),
        .exc_vector_addr(exc_vector_addr), .fetch_addr(fetch_addr),
        .fetch_kind(fetch_kind), .core_ack(core_ack), .fetch_req(fetch_req),
        .fetch_vector(fetch_vector));

    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            $display("ERROR at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [2:0] idx, input logic [31:0] exp);
        prio_rd_index = idx;
        tick();
        check(prio_rd_data, exp, "priority readback");
    endtask

    function automatic int pick(input logic [31:0] s);
        int w;
        w = -1;
        for (int n = 0; n < 32; n++)
            if (s[n] && (w < 0 || prio[n] < prio[w]))
                w = n;
        return w;
    endfunction

    task automatic t_reset();
        check(32'(irq_pending), 32'h0, "pending after reset");
        check(32'(nmi_request), 32'h0, "nmi after reset");
        check(32'(exc_vector), 32'h0, "vector after reset");
        for (int r = 0; r < 8; r++)
            rd_check(3'(r), 32'h0000_0000);
    endtask

    // Distinct fields per register expose index and position slips
    task automatic t_prio_regs();
        logic [1:0] f [4];
        logic [31:0] exp [8];
        for (int r = 0; r < 8; r++) begin
            f[0] = 2'(r);
            f[1] = {1'b1, 1'(r >> 2)};
            f[2] = ~2'(r);
            f[3] = 2'h2;
            exp[r] = 32'h0;
            for (int k = 0; k < 4; k++) begin
                prio[4 * r + k] = f[k];
                exp[r] |= 32'(f[k]) << (8 * k + 6);
            end
            prio_wr = 1'b1;
            prio_wr_index = 3'(r);
            prio_wr_data = exp[r] | 32'h3F3F_3F3F;
            tick();
            prio_wr = 1'b0;
            rd_check(3'(r), exp[r]);
        end
        for (int r = 7; r >= 0; r--)
            rd_check(3'(r), exp[r]);
    endtask

    task automatic t_source_map();
        for (int i = 0; i < 32; i++) begin
            src = 32'h1 << i;
            repeat (2) tick();
            check(32'(irq_pending), 32'(ASSIGNED[i]), "line pending");
            if (ASSIGNED[i]) begin
                check(32'(irq_number), 32'(i), "line number");
                check(32'(irq_priority), 32'(prio[i]), "line level");
            end
        end
    endtask

    task automatic t_select_take();
        logic [1:0] pulse;
        logic [5:0] vec;
        logic [31:0] addr;
        int w;
        src = ASSIGNED;
        for (int i = 0; src != 32'h0; i++) begin
            repeat (2) tick();
            w = pick(src);
            check(32'(irq_number), 32'(w), "winner");
            check(32'(irq_priority), 32'(prio[w]), "winner level");
            u_core_model.take(i % 3, pulse, vec, addr);
            check(32'(pulse), 32'h2, "take pulse");
            check(32'(vec), 32'(w + 16), "taken vector");
            check(addr, 32'((w + 16) * 4), "taken address");
            src[w] = 1'b0;
        end
        repeat (2) tick();
        check(32'(irq_pending), 32'h0, "all cleared");
        u_core_model.take(0, pulse, vec, addr);
        check(32'(pulse), 32'h0, "refused pulse");
        check(32'(vec), 32'(w + 16), "refused keeps vector");
    endtask

    task automatic t_nmi();
        logic [1:0] pulse;
        logic [5:0] vec;
        logic [31:0] addr;
        nmi_pin_select = 1'b1;
        src = 32'h8000_0000;
        nmi_pin_n = 1'b0;
        repeat (2) tick();
        check(32'(nmi_request), 32'h0, "nmi early");
        tick();
        check(32'(nmi_request), 32'h1, "nmi raised");
        u_core_model.take(0, pulse, vec, addr);
        check(32'(vec), 32'(irq_map_pkg::VEC_NMI), "nmi beats irq");
        check(addr, 32'h0000_0008, "nmi address");
        nmi_pin_n = 1'b1;
        repeat (4) tick();
        check(32'(nmi_request), 32'h0, "nmi released");
        nmi_pin_select = 1'b0;
        nmi_pin_n = 1'b0;
        repeat (4) tick();
        check(32'(nmi_request), 32'h0, "nmi pin not selected");
        u_core_model.take(1, pulse, vec, addr);
        check(32'(vec), 32'h2F, "irq while pin not selected");
        nmi_pin_n = 1'b1;
        src = 32'h0;
    endtask

    task automatic t_fetch();
        logic [31:0] addr;
        logic [1:0] kind;
        logic [1:0] exp;
        for (int v = 0; v < 64; v++) begin
            u_core_model.fetch(6'(v), v == 63, addr, kind);
            if (v >= 48)
                exp = 2'h3;
            else if (v >= 16)
                exp = 2'h2;
            else if (v <= 3 || v == 11 || v == 14 || v == 15)
                exp = 2'h0;
            else
                exp = 2'h1;
            check(32'(kind), 32'(exp), "entry class");
            if (v < 48)
                check(addr, 32'(v * 4), "entry address");
        end
    endtask

    initial begin
        rst_n = 1'b0;
        src = 32'h0;
        nmi_pin_n = 1'b1;
        nmi_pin_select = 1'b0;
        prio_wr = 1'b0;
        prio_wr_index = 3'h0;
        prio_wr_data = 32'h0;
        prio_rd_index = 3'h0;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick();
        t_reset();
        t_prio_regs();
        t_source_map();
        t_select_take();
        t_nmi();
        t_fetch();
        give_verdict();
    end
endmodule
`default_nettype wire
